// ==== design/node_reset_and_clock_watch.sv ====
// reset merging, crystal detection and clock watch with apb registers
//
// Register access over APB and the placing of the registers were decided locally.
module node_reset_and_clock_watch
    import node_reset_pkg::*;
#(
    parameter int unsigned SOFT_INIT_CYC = SOFT_INIT_CYC_DEF,
    parameter int unsigned POWER_INIT_CYC = POWER_INIT_CYC_DEF,
    parameter int unsigned HEAVY_INIT_CYC = HEAVY_INIT_CYC_DEF,
    parameter int unsigned EXT_CYC = EXT_CYC_DEF
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pins and state machine
    input wire logic crystal_in_pin,
    input wire logic strobe_reset_pin_n,
    input wire logic comm_wdog_expire,
    input wire logic [3:0] main_state_code,
    // ports toward the periphery
    output logic [3:0] data_port_out,
    output logic data_port_oe,
    output logic [3:0] par_port_out,
    output logic par_port_oe,
    output logic data_strobe,
    output logic par_strobe,
    output logic clk_gen_fast,
    output logic node_ready
);

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    logic pready_q, pslverr_q;
    logic [31:0] prdata_q;
    wire setup = psel & ~penable;
    wire wr_acc = psel & penable & pready_q & pwrite;
    wire sel_ctrl = paddr == CTRL_OFS;
    wire sel_stat = paddr == STATUS_OFS;
    wire sel_par = paddr == PARAM_OFS;
    wire sel_data = paddr == DATA_OFS;
    wire sel_cause = paddr == CAUSE_OFS;
    wire mapped = sel_ctrl | sel_stat | sel_par | sel_data | sel_cause;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    phase_type phase_q, phase_d;
    logic [31:0] init_cnt_q, init_cnt_d;
    logic [31:0] por_cnt_q;
    logic [31:0] cwd_cnt_q;
    logic [31:0] low_cnt_q;
    logic [7:0] per_cnt_q;
    logic xin_q, fast_q, ext_hold_q, wdog_en_q, block_q;
    logic dstb_q, pstb_q, ready_q;
    port_out_type data_q, par_q;
    cause_type cause_q, cause_now;

    // crystal edges and clock watch
    wire xtal_edge = crystal_in_pin ^ xin_q;
    wire xtal_rise = crystal_in_pin & ~xin_q;
    wire cwd_fire = (cwd_cnt_q == CWD_CYC - 1) & ~xtal_edge;

    // strobe pin timer
    wire ext_fire = (low_cnt_q == EXT_CYC - 1) & ~strobe_reset_pin_n;

    // reset sources
    wire [3:0] code_m1 = main_state_code - 4'h1;
    wire illegal = (main_state_code == 4'h0) |
        ((main_state_code & code_m1) != 4'h0);
    wire node_cmd = wr_acc & sel_ctrl & pwdata[CTRL_NODE_RST_BIT];
    wire bcast_cmd = wr_acc & sel_ctrl & pwdata[CTRL_BCAST_RST_BIT];
    wire wdog_evt = wdog_en_q & comm_wdog_expire;
    assign cause_now = '{ext: ext_fire, illegal: illegal,
        comm_wdog: wdog_evt, bcast: bcast_cmd, node: node_cmd,
        clk_wdog: cwd_fire};
    wire rst_evt = |cause_now;
    wire reset_load = rst_evt & (phase_q != PH_POR);

    // accepted port writes, only while running
    wire run = phase_q == PH_RUN;
    wire par_wr = wr_acc & sel_par & run & ~reset_load;
    wire data_refused = block_q | ~run;
    wire data_wr = wr_acc & sel_data & ~data_refused & ~reset_load;

    // ----------------------------------------------------------------
    // crystal detect and clock watchdog
    // ----------------------------------------------------------------
    // period counter: cycles between rising crystal edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xin_q <= 1'b0;
            per_cnt_q <= 8'h00;
            fast_q <= 1'b0;
        end else begin
            xin_q <= crystal_in_pin;
            if (xtal_rise) begin
                per_cnt_q <= 8'h00;
                fast_q <= per_cnt_q < XTAL_SPLIT;
            end else if (per_cnt_q != 8'hFF) begin
                per_cnt_q <= per_cnt_q + 8'h01;
            end
        end
    end

    // watchdog saturates so a dead crystal fires only once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cwd_cnt_q <= 32'h0;
        end else if (xtal_edge) begin
            cwd_cnt_q <= 32'h0;
        end else if (cwd_cnt_q != CWD_CYC) begin
            cwd_cnt_q <= cwd_cnt_q + 32'h1;
        end
    end

    // ----------------------------------------------------------------
    // external reset by strobe pin
    // ----------------------------------------------------------------
    // low timer saturates: fires on expiry, hold lasts while pin is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_cnt_q <= 32'h0;
            ext_hold_q <= 1'b0;
        end else begin
            if (strobe_reset_pin_n) begin
                low_cnt_q <= 32'h0;
            end else if (low_cnt_q != EXT_CYC) begin
                low_cnt_q <= low_cnt_q + 32'h1;
            end
            if (ext_fire) begin
                ext_hold_q <= 1'b1;
            end else if (strobe_reset_pin_n) begin
                ext_hold_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // phase sequencing
    // ----------------------------------------------------------------
    always_comb begin
        phase_d = phase_q;
        init_cnt_d = init_cnt_q;
        case (phase_q)
            PH_POR: begin
                if (por_cnt_q == POR_CYC - 1) begin
                    phase_d = PH_INIT;
                    init_cnt_d = POWER_INIT_CYC - 1;
                end
            end
            PH_INIT: begin
                if (rst_evt) begin
                    init_cnt_d = SOFT_INIT_CYC - 1;
                end else if (init_cnt_q != 32'h0) begin
                    init_cnt_d = init_cnt_q - 32'h1;
                end else if (!ext_hold_q) begin
                    phase_d = PH_RUN;
                end
            end
            PH_RUN: begin
                if (rst_evt) begin
                    phase_d = PH_INIT;
                    init_cnt_d = SOFT_INIT_CYC - 1;
                end
            end
            default: begin
                phase_d = PH_INIT;
                init_cnt_d = SOFT_INIT_CYC - 1;
            end
        endcase
    end

    // phase registers and power-on pulse counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q <= PH_POR;
            init_cnt_q <= 32'h0;
            por_cnt_q <= 32'h0;
            ready_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            init_cnt_q <= init_cnt_d;
            if (phase_q == PH_POR) begin
                por_cnt_q <= por_cnt_q + 32'h1;
            end
            ready_q <= phase_d == PH_RUN;
        end
    end

    // ----------------------------------------------------------------
    // output ports, strobes and exchange block
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_q <= '{val: OUT_ALL_ONES, oe: 1'b0};
            par_q <= '{val: OUT_ALL_ONES, oe: 1'b0};
            block_q <= 1'b1;
            dstb_q <= 1'b0;
            pstb_q <= 1'b0;
            cause_q <= '0;
        end else begin
            dstb_q <= reset_load | data_wr;
            pstb_q <= reset_load | par_wr;
            if (reset_load) begin
                data_q <= '{val: OUT_ALL_ONES, oe: 1'b0};
                par_q <= '{val: OUT_ALL_ONES, oe: 1'b0};
                block_q <= 1'b1;
                cause_q <= cause_now;
            end else begin
                if (par_wr) begin
                    par_q <= '{val: pwdata[PORT_W-1:0], oe: 1'b1};
                    block_q <= 1'b0;
                end
                if (data_wr) begin
                    data_q <= '{val: pwdata[PORT_W-1:0], oe: 1'b1};
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // apb response, registered in the setup cycle
    // ----------------------------------------------------------------
    wire [31:0] rd_ctrl = {31'h0, wdog_en_q};
    wire [31:0] rd_stat = {25'h0, ext_hold_q, fast_q, block_q, ready_q,
        phase_q};
    wire [31:0] rd_cause = {26'h0, cause_q};
    wire [31:0] rd_mux = sel_ctrl ? rd_ctrl :
        sel_stat ? rd_stat :
        sel_cause ? rd_cause : RDATA_ZERO;
    wire err_d = ~mapped | (pwrite & sel_data & data_refused) |
        (pwrite & sel_par & ~run);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= RDATA_ZERO;
            wdog_en_q <= 1'b0;
        end else begin
            pready_q <= setup;
            pslverr_q <= setup & err_d;
            prdata_q <= (setup & ~pwrite) ? rd_mux : RDATA_ZERO;
            if (wr_acc & sel_ctrl) begin
                wdog_en_q <= pwdata[CTRL_WDOG_EN_BIT];
            end
        end
    end

    // outputs straight from flops
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign data_port_out = data_q.val;
    assign data_port_oe = data_q.oe;
    assign par_port_out = par_q.val;
    assign par_port_oe = par_q.oe;
    assign data_strobe = dstb_q;
    assign par_strobe = pstb_q;
    assign clk_gen_fast = fast_q;
    assign node_ready = ready_q;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_XTAL_SLOW: assert property (
        xtal_rise && per_cnt_q >= XTAL_SPLIT |=> !clk_gen_fast)
        else $error("slow crystal not detected");
    AST_CLK_WDOG: assert property (
        cwd_fire && phase_q != PH_POR |=> phase_q == PH_INIT
        && par_port_out == OUT_ALL_ONES && data_strobe)
        else $error("clock loss did not reset node");
    AST_OUT_ONES: assert property (
        reset_load |=> data_port_out == OUT_ALL_ONES && !data_port_oe
        && par_port_out == OUT_ALL_ONES && !par_port_oe)
        else $error("outputs not forced to ones and off");
    AST_STROBES: assert property (
        reset_load |=> data_strobe && par_strobe ##1 !data_strobe)
        else $error("strobes not pulsed together");
    AST_NO_POR_STROBE: assert property (
        phase_q == PH_POR |-> !data_strobe && !par_strobe)
        else $error("strobe during power-on");
    AST_DATA_REFUSED: assert property (
        wr_acc && sel_data && block_q && !reset_load
        |=> $stable(data_port_out) && $stable(data_port_oe))
        else $error("blocked data write took effect");
    AST_SOFT_INIT: assert property (
        reset_load |=> phase_q == PH_INIT && init_cnt_q == SOFT_INIT_CYC - 1)
        else $error("soft init length wrong");
    AST_INIT_DONE: assert property (
        phase_q == PH_INIT && init_cnt_q == 32'h0 && !ext_hold_q
        && !rst_evt |=> phase_q == PH_RUN && node_ready)
        else $error("init did not finish");
    AST_POWER_INIT: assert property (
        phase_q == PH_POR && phase_d == PH_INIT
        |=> init_cnt_q == POWER_INIT_CYC - 1)
        else $error("power init length wrong");
    AST_HEAVY_BOUND: assert property (
        init_cnt_q < HEAVY_INIT_CYC)
        else $error("init longer than heavy load bound");
    AST_POR_LEN: assert property (
        phase_q == PH_POR && phase_d != PH_POR |-> por_cnt_q == POR_CYC - 1)
        else $error("power-on pulse length wrong");
    AST_EXT_FIRE: assert property (
        ext_fire |-> low_cnt_q == EXT_CYC - 1 ##1 ext_hold_q)
        else $error("external reset timing wrong");
    AST_EXT_HOLD: assert property (
        ext_hold_q |-> phase_q != PH_RUN)
        else $error("running while strobe pin holds reset");
    AST_ILLEGAL: assert property (
        illegal && phase_q != PH_POR |=> phase_q == PH_INIT && block_q)
        else $error("illegal state code did not reset");
    AST_QUIET: assert property (
        phase_q != PH_RUN |-> !data_port_oe && !par_port_oe && !node_ready)
        else $error("ports driven during init");

    COV_RUN: cover property (phase_q == PH_INIT ##1 phase_q == PH_RUN);
    COV_EXT: cover property (ext_fire);
    COV_PAR_WR: cover property (par_wr ##1 !block_q);
    COV_CLK_LOSS: cover property (cwd_fire && phase_q == PH_RUN);

endmodule : node_reset_and_clock_watch

// ==== shared/node_reset_pkg.sv ====
// constants, types and register map of the reset and clock watch block
package node_reset_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] PARAM_OFS = 8'h08;
    localparam logic [7:0] DATA_OFS = 8'h0C;
    localparam logic [7:0] CAUSE_OFS = 8'h10;

    // control bits
    localparam int CTRL_WDOG_EN_BIT = 0;
    localparam int CTRL_NODE_RST_BIT = 1;
    localparam int CTRL_BCAST_RST_BIT = 2;

    // port values and reset values
    localparam int PORT_W = 4;
    localparam logic [3:0] OUT_ALL_ONES = 4'hF;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_KHZ = 40000;
    localparam int unsigned XTAL_LO_KHZ = 5333;
    localparam int unsigned XTAL_HI_KHZ = 16000;
    localparam logic [7:0] XTAL_SPLIT =
        8'((CLK_KHZ / XTAL_LO_KHZ + CLK_KHZ / XTAL_HI_KHZ) / 2);
    localparam int unsigned CWD_US = 20;
    localparam int unsigned CWD_CYC = CWD_US * CLK_KHZ / 1000 + 1;
    localparam int unsigned POR_MIN_NS = 4000;
    localparam int unsigned POR_MAX_NS = 6000;
    localparam int unsigned POR_CYC =
        (POR_MIN_NS + POR_MAX_NS) / 2 * CLK_KHZ / 1000000;
    localparam int unsigned SOFT_INIT_MS = 2;
    localparam int unsigned SOFT_INIT_CYC_DEF = SOFT_INIT_MS * CLK_KHZ;
    localparam int unsigned POWER_INIT_MS = 30;
    localparam int unsigned POWER_INIT_CYC_DEF = POWER_INIT_MS * CLK_KHZ;
    localparam int unsigned HEAVY_INIT_MS = 1000;
    localparam int unsigned HEAVY_INIT_CYC_DEF = HEAVY_INIT_MS * CLK_KHZ;
    localparam int unsigned EXT_NORESET_MS = 90;
    localparam int unsigned EXT_EXEC_MS = 99;
    localparam int unsigned EXT_CYC_DEF = EXT_NORESET_MS * CLK_KHZ + 1;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        PH_POR = 3'b001,
        PH_INIT = 3'b010,
        PH_RUN = 3'b100
    } phase_type;

    typedef struct packed {
        logic [3:0] val;
        logic oe;
    } port_out_type;

    typedef struct packed {
        logic ext;
        logic illegal;
        logic comm_wdog;
        logic bcast;
        logic node;
        logic clk_wdog;
    } cause_type;

endpackage : node_reset_pkg

// ==== sim/field_master_model.sv ====
// apb master playing the field-bus master toward the node
module field_master_model
    import node_reset_pkg::*;
(
    // clock
    input wire logic pclk,
    // apb master side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 100ps;

    // idle bus at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // one transfer, held until pready; unknown result on no answer
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        rd = (n < 40) ? prdata : 32'hX;
        er = (n < 40) ? pslverr : 1'bx;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d; // released data shows no stale value
        @(posedge pclk);
    endtask : xfer

    // parameters always go out before data
    task automatic exchange(input logic [31:0] pv, input logic [31:0] dv,
        output logic e1, output logic e2);
        logic [31:0] rd;
        xfer(1'b1, PARAM_OFS, pv, rd, e1);
        xfer(1'b1, DATA_OFS, dv, rd, e2);
    endtask : exchange
endmodule : field_master_model

// ==== sim/node_reset_and_clock_watch_tb_top.sv ====
// self-checking bench of the reset and clock watch block
module node_reset_and_clock_watch_tb_top
    import node_reset_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int SOFT = 20;
    localparam int PWR = 100;
    localparam int EXT = 50;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic crystal_in_pin, strobe_reset_pin_n, comm_wdog_expire;
    logic erv, e1, e2, data_port_oe, par_port_oe, data_strobe, par_strobe;
    logic [3:0] main_state_code, data_port_out, par_port_out;
    logic clk_gen_fast, node_ready;
    int num_errors, checked, seed, both_cnt, xtal_half, xcnt, b0;

    node_reset_and_clock_watch #(.SOFT_INIT_CYC(SOFT),
        .POWER_INIT_CYC(PWR), .EXT_CYC(EXT)) uut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .crystal_in_pin(crystal_in_pin),
        .strobe_reset_pin_n(strobe_reset_pin_n),
        .comm_wdog_expire(comm_wdog_expire),
        .main_state_code(main_state_code), .data_port_out(data_port_out),
        .data_port_oe(data_port_oe), .par_port_out(par_port_out),
        .par_port_oe(par_port_oe), .data_strobe(data_strobe),
        .par_strobe(par_strobe), .clk_gen_fast(clk_gen_fast),
        .node_ready(node_ready));
    field_master_model u_master (.pclk(pclk), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    // 40 mhz clock
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // crystal, still while xtal_half is zero; paired strobe counter
    always @(posedge pclk) begin
        if (xtal_half != 0) begin
            xcnt <= (xcnt + 1 >= xtal_half) ? 0 : xcnt + 1;
            if (xcnt + 1 >= xtal_half)
                crystal_in_pin <= ~crystal_in_pin;
        end
        if (data_strobe === 1'b1 && par_strobe === 1'b1) begin
            both_cnt <= both_cnt + 1;
            if (xtal_half == 0)
                xtal_half <= 4; // crystal back, now the slow one
        end
    end

    task automatic chk(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    function automatic logic [31:0] status_exp(input logic [2:0] ph,
        input logic blk, input logic fst);
        return {25'h0, 1'b0, fst, blk, ph == 3'b100, ph};
    endfunction : status_exp

    task automatic rd(input logic [7:0] a, input logic ee);
        u_master.xfer(1'b0, a, 32'h0, rdv, erv);
        chk("read pslverr", 32'(erv), 32'(ee));
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic ee);
        u_master.xfer(1'b1, a, d, rdv, erv);
        chk("write pslverr", 32'(erv), 32'(ee));
    endtask : wr

    task automatic chk_off;
        chk("data_port_out", 32'(data_port_out), 32'(OUT_ALL_ONES));
        chk("data_port_oe", 32'(data_port_oe), 32'h0);
        chk("par_port_out", 32'(par_port_out), 32'(OUT_ALL_ONES));
        chk("par_port_oe", 32'(par_port_oe), 32'h0);
        chk("node_ready low", 32'(node_ready), 32'h0);
    endtask : chk_off

    task automatic wait_ready(input int lim);
        int n;
        n = 0;
        while (node_ready !== 1'b1 && n < lim) begin
            @(posedge pclk);
            n++;
        end
        chk("ready in time", 32'(node_ready), 32'h1);
    endtask : wait_ready

    // parameter then data, ports must follow
    task automatic exch(input logic [31:0] pv, input logic [31:0] dv);
        u_master.exchange(pv, dv, e1, e2);
        chk("param err", 32'(e1), 32'h0);
        chk("data err", 32'(e2), 32'h0);
        chk("par_port_out", 32'(par_port_out), 32'(pv[3:0]));
        chk("par_port_oe", 32'(par_port_oe), 32'h1);
        chk("data_port_out", 32'(data_port_out), 32'(dv[3:0]));
        chk("data_port_oe", 32'(data_port_oe), 32'h1);
    endtask : exch

    // waits for the paired strobe after an event, then inspects
    task automatic fired(input logic [31:0] cause, input int lim);
        int n;
        n = 0;
        while (both_cnt == b0 && n < lim) begin
            @(posedge pclk);
            n++;
        end
        @(posedge pclk);
        chk("strobe pairs", 32'(both_cnt - b0), 32'h1);
        chk_off();
        rd(CAUSE_OFS, 1'b0);
        chk("cause", rdv, cause);
        wr(DATA_OFS, 32'hF, 1'b1);
    endtask : fired

    // main sequence
    initial begin
        seed = 98820;
        num_errors = 0;
        checked = 0;
        both_cnt = 0;
        xcnt = 0;
        xtal_half = 1;
        presetn = 1'b0;
        crystal_in_pin = 1'b0;
        strobe_reset_pin_n = 1'b1;
        comm_wdog_expire = 1'b0;
        main_state_code = 4'h1;
        repeat (5) @(posedge pclk);
        chk_off();
        presetn <= 1'b1;
        rd(STATUS_OFS, 1'b0);
        chk("phase", 32'(rdv[2:0]), 32'h1);
        repeat (150) @(posedge pclk);
        rd(STATUS_OFS, 1'b0);
        chk("phase at 4us", 32'(rdv[2:0]), 32'h1);
        repeat (84) @(posedge pclk);
        rd(STATUS_OFS, 1'b0);
        chk("phase at 6us", 32'(rdv[2:0]), 32'h2);
        wr(PARAM_OFS, 32'h3, 1'b1);
        wait_ready(PWR - 40);
        chk("no power-on strobe", 32'(both_cnt), 32'h0);
        rd(STATUS_OFS, 1'b0);
        chk("status", rdv, status_exp(3'b100, 1'b1, 1'b1));
        wr(DATA_OFS, 32'h5, 1'b1);
        rd(8'h14, 1'b1);
        chk("unmapped", rdv, RDATA_ZERO);
        rd(CTRL_OFS, 1'b0);
        chk("ctrl reset", rdv, 32'h0);
        $display("test power-on finished");
        for (int i = 0; i < 6; i++) begin
            main_state_code <= 4'h1 << ($random(seed) & 3);
            exch($random(seed), $random(seed));
        end
        rd(STATUS_OFS, 1'b0);
        chk("unblocked", rdv, status_exp(3'b100, 1'b0, 1'b1));
        b0 = both_cnt;
        comm_wdog_expire <= 1'b1;
        @(posedge pclk);
        comm_wdog_expire <= 1'b0;
        repeat (5) @(posedge pclk);
        chk("disabled wdog", 32'(both_cnt - b0), 32'h0);
        $display("test exchange finished");
        for (int k = 0; k < 5; k++) begin
            b0 = both_cnt;
            case (k)
                0: wr(CTRL_OFS, 32'h2, 1'b0);
                1: wr(CTRL_OFS, 32'h4, 1'b0);
                2: begin
                    wr(CTRL_OFS, 32'h1, 1'b0);
                    b0 = both_cnt;
                    comm_wdog_expire <= 1'b1;
                    @(posedge pclk);
                    comm_wdog_expire <= 1'b0;
                end
                3: begin
                    main_state_code <= 4'h3;
                    @(posedge pclk);
                    main_state_code <= 4'h1;
                end
                default: begin
                    xtal_half <= 0;
                    repeat (790) @(posedge pclk);
                    chk("early clock reset", 32'(node_ready), 32'h1);
                end
            endcase
            fired(32'h1 << ((k + 1) % 5), 30);
            wait_ready(SOFT + 10);
            wr(DATA_OFS, 32'h6, 1'b1);
            exch($random(seed), $random(seed));
        end
        chk("slow crystal", 32'(clk_gen_fast), 32'h0);
        $display("test reset sources finished");
        b0 = both_cnt;
        strobe_reset_pin_n <= 1'b0;
        repeat (EXT - 2) @(posedge pclk);
        strobe_reset_pin_n <= 1'b1;
        repeat (5) @(posedge pclk);
        chk("short low", 32'(both_cnt - b0), 32'h0);
        strobe_reset_pin_n <= 1'b0;
        fired(32'h20, EXT + 10);
        repeat (SOFT + 20) @(posedge pclk);
        chk("held in reset", 32'(node_ready), 32'h0);
        chk("one ext fire", 32'(both_cnt - b0), 32'h1);
        strobe_reset_pin_n <= 1'b1;
        wait_ready(SOFT + 10);
        $display("test external finished");
        tally_and_finish();
    end

    // hang guard
    initial begin
        repeat (10000) @(posedge pclk);
        num_errors++;
        tally_and_finish();
    end
endmodule : node_reset_and_clock_watch_tb_top
